//--- hdl/fach_check.sv
`timescale 1ns/100ps
`default_nettype none
`include "fach_consts.svh"
module fach_check (
  fach_if.chk c
);
  function automatic logic fach_aligned(input logic [7:0] drv, input logic [31:0] off);
    if (drv == `FACH_DRV_INT) begin
      fach_aligned = (off[1:0] == 2'h0); // R3 R14
    end else begin
      fach_aligned = (off[0] == 1'h0); // R4 R15
    end
  endfunction

  always_comb begin
    logic copy;
    logic [15:0] lim;
    copy = (c.cmd == fach_pkg::FACH_CMD_COPY);
    lim = copy ? `FACH_CP_MAX : `FACH_WR_MAX; // R1 R13
    c.err = `FACH_ERR_NONE;
    if (c.cmd > fach_pkg::FACH_CMD_COPY) begin
      c.err = `FACH_ERR_CMD;
    end else if (c.cmd == fach_pkg::FACH_CMD_LOCK_SET || c.cmd == fach_pkg::FACH_CMD_LOCK_CLR) begin
      c.err = `FACH_ERR_NONE;
    end else if (c.cpu_run && (c.dst_prot || (copy && c.src_prot))) begin
      c.err = `FACH_ERR_PROT; // R5
    end else if (c.offset >= c.size || (copy && c.src_offset >= c.src_size)) begin
      c.err = `FACH_ERR_RANGE; // R16
    end else if (!fach_aligned(c.drive, c.offset)) begin
      c.err = `FACH_ERR_ALIGN; // R16
    end else if (copy && !fach_aligned(c.src_drive, c.src_offset)) begin
      c.err = `FACH_ERR_ALIGN; // R16
    end else if (c.count > lim) begin
      c.err = `FACH_ERR_COUNT; // R16
    end
  end
endmodule
`default_nettype wire

//--- hdl/fach_lock.sv
`timescale 1ns/100ps
`default_nettype none
`include "fach_consts.svh"
module fach_lock #(
  parameter int LOCK_N = `FACH_LOCK_N
) (
  input wire logic sys_clk,
  input wire logic rstn,
  fach_if.lkp l
);
  typedef struct packed {
    logic [LOCK_N-1:0] vld;
    logic [LOCK_N-1:0][`FACH_KEY_W-1:0] key;
  } fach_lock_s;
  fach_lock_s r;
  fach_lock_s next_r;

  always_comb begin
    logic placed;
    placed = 1'b0;
    next_r = r;
    l.lk_hit = 1'b0;
    l.acc_hit = 1'b0;
    l.lk_room = ~&r.vld;
    for (int i = 0; i < LOCK_N; i++) begin
      if (r.vld[i] && r.key[i] == l.lk_key) begin
        l.lk_hit = 1'b1;
      end
      if (r.vld[i] && r.key[i] == l.acc_key) begin
        l.acc_hit = 1'b1; // R9
      end
    end
    for (int i = 0; i < LOCK_N; i++) begin
      if (l.lk_set && !l.lk_hit && !placed && !r.vld[i]) begin
        next_r.vld[i] = 1'b1; // R9
        next_r.key[i] = l.lk_key;
        placed = 1'b1;
      end
      if (l.lk_clr && r.vld[i] && r.key[i] == l.lk_key) begin
        next_r.vld[i] = 1'b0; // R10
      end
    end
    if (l.restart) begin
      next_r.vld = '0; // R11
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule
`default_nettype wire

//--- hdl/fach_top.sv
// Overview of operation
// R1 - Batch write carries 0 to 960 bytes per request.
// R2 - Requester splits larger writes, advancing offset and count each part.
// R3 - Internal memory drive offsets are multiples of four within file size.
// R4 - Other drive offsets are even and within file size.
// R5 - While CPU runs, parameter or executing file targets get a NAK; executing files are refused only on the internal memory drive.
// R6 - Attribute field of write, fill, lock and copy is ignored.
// R7 - Fill repeats the one-word pattern from offset for the byte count.
// R8 - Fill goes bytewise; a lone last byte writes only the low byte.
// R9 - Lock registration marks the file locked against other devices.
// R10 - Lock clear removes the lock so others may access again.
// R11 - All locks drop when the CPU restarts.
// R12 - Copy reads source file at offset and overwrites destination file.
// R13 - Copy moves 0 to 480 bytes per request.
// R14 - Copy offsets on internal memory drive are multiples of four.
// R15 - Copy offsets on other drives are even.
// R16 - Bad offset range, alignment or byte count is answered with NAK.
`timescale 1ns/100ps
`default_nettype none
`include "fach_consts.svh"
module fach_top #(
  parameter int LOCK_N = `FACH_LOCK_N
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [2:0] req_cmd,
  input wire logic [7:0] req_drive,
  input wire logic [15:0] req_file,
  input wire logic [31:0] req_offset,
  input wire logic [31:0] req_size,
  input wire logic req_dst_param,
  input wire logic req_dst_exec,
  input wire logic [7:0] req_src_drive,
  input wire logic [15:0] req_src_file,
  input wire logic [31:0] req_src_offset,
  input wire logic [31:0] req_src_size,
  input wire logic req_src_param,
  input wire logic req_src_exec,
  input wire logic [15:0] req_count,
  input wire logic [15:0] req_pattern,
  input wire logic [7:0] req_attr,
  input wire logic din_valid,
  output logic din_ready,
  input wire logic [7:0] din_data,
  output logic mem_wr,
  output logic mem_rd,
  output logic [7:0] mem_drive,
  output logic [15:0] mem_file,
  output logic [31:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic mem_rvalid,
  input wire logic [7:0] mem_rdata,
  output logic rsp_valid,
  output logic rsp_nak,
  output logic [3:0] rsp_code,
  input wire logic cpu_run,
  input wire logic cpu_restart,
  input wire logic [7:0] acc_drive,
  input wire logic [15:0] acc_file,
  output logic acc_denied
);
  fach_pkg::fach_top_s r;
  fach_pkg::fach_top_s next_r;
  fach_if bus ();

  ////////////////////////////////////////////////////////////////////////
  // Checker and lock table
  fach_check u_check (
    .c(bus.chk)
  );

  fach_lock #(
    .LOCK_N(LOCK_N)
  ) u_lock (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .l(bus.lkp)
  );

  assign bus.cmd = r.cmd;
  assign bus.drive = r.drive;
  assign bus.src_drive = r.src_drive;
  assign bus.offset = r.dst_addr;
  assign bus.size = r.size;
  assign bus.src_offset = r.src_addr;
  assign bus.src_size = r.src_size;
  assign bus.count = r.remain;
  assign bus.dst_prot = r.dst_prot;
  assign bus.src_prot = r.src_prot;
  assign bus.cpu_run = cpu_run;
  assign bus.lk_set = r.lk_set;
  assign bus.lk_clr = r.lk_clr;
  assign bus.restart = cpu_restart;
  assign bus.lk_key = {r.drive, r.file};
  assign bus.acc_key = {acc_drive, acc_file};

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    next_r = r;
    next_r.mem_wr = 1'b0;
    next_r.mem_rd = 1'b0;
    next_r.rsp_valid = 1'b0;
    next_r.lk_set = 1'b0;
    next_r.lk_clr = 1'b0;
    next_r.acc_denied = bus.acc_hit; // R9
    unique case (r.st)
      fach_pkg::FACH_ST_IDLE: begin
        next_r.req_ready = 1'b1;
        if (req_valid && r.req_ready) begin
          // Attribute field is not latched
          next_r.req_ready = 1'b0; // R6
          next_r.cmd = req_cmd;
          next_r.drive = req_drive;
          next_r.file = req_file;
          next_r.size = req_size;
          next_r.src_drive = req_src_drive;
          next_r.src_file = req_src_file;
          next_r.src_size = req_src_size;
          next_r.dst_addr = req_offset;
          next_r.src_addr = req_src_offset;
          next_r.remain = req_count;
          next_r.pattern = req_pattern;
          next_r.hi = 1'b0;
          next_r.dst_prot = req_dst_param
            || (req_dst_exec && req_drive == `FACH_DRV_INT); // R5
          next_r.src_prot = req_src_param
            || (req_src_exec && req_src_drive == `FACH_DRV_INT); // R5
          next_r.err = `FACH_ERR_NONE;
          next_r.st = fach_pkg::FACH_ST_CHECK;
        end
      end
      fach_pkg::FACH_ST_CHECK: begin
        next_r.st = fach_pkg::FACH_ST_DONE;
        if (bus.err != `FACH_ERR_NONE) begin
          next_r.err = bus.err; // R16
        end else begin
          unique case (r.cmd)
            fach_pkg::FACH_CMD_LOCK_SET: begin
              if (!bus.lk_hit && !bus.lk_room) begin
                next_r.err = `FACH_ERR_LOCK;
              end else begin
                next_r.lk_set = 1'b1; // R9
              end
            end
            fach_pkg::FACH_CMD_LOCK_CLR: begin
              next_r.lk_clr = 1'b1; // R10
            end
            fach_pkg::FACH_CMD_WRITE: begin
              if (r.remain != 16'h0000) begin
                next_r.din_ready = 1'b1; // R1
                next_r.st = fach_pkg::FACH_ST_WRITE;
              end
            end
            fach_pkg::FACH_CMD_FILL: begin
              if (r.remain != 16'h0000) begin
                next_r.st = fach_pkg::FACH_ST_FILL; // R7
              end
            end
            default: begin
              if (r.remain != 16'h0000) begin
                next_r.st = fach_pkg::FACH_ST_CP_RD; // R12
              end
            end
          endcase
        end
      end
      fach_pkg::FACH_ST_WRITE: begin
        if (din_valid && r.din_ready) begin
          next_r.mem_wr = 1'b1;
          next_r.mem_drive = r.drive;
          next_r.mem_file = r.file;
          next_r.mem_addr = r.dst_addr;
          next_r.mem_wdata = din_data;
          next_r.dst_addr = r.dst_addr + 32'h0000_0001;
          next_r.remain = r.remain - 16'h0001;
          if (r.remain == 16'h0001) begin
            next_r.din_ready = 1'b0;
            next_r.st = fach_pkg::FACH_ST_DONE;
          end
        end
      end
      fach_pkg::FACH_ST_FILL: begin
        next_r.mem_wr = 1'b1; // R7
        next_r.mem_drive = r.drive;
        next_r.mem_file = r.file;
        next_r.mem_addr = r.dst_addr;
        next_r.mem_wdata = r.hi ? r.pattern[15:8] : r.pattern[7:0]; // R8
        next_r.hi = ~r.hi;
        next_r.dst_addr = r.dst_addr + 32'h0000_0001;
        next_r.remain = r.remain - 16'h0001;
        if (r.remain == 16'h0001) begin
          next_r.st = fach_pkg::FACH_ST_DONE; // R8
        end
      end
      fach_pkg::FACH_ST_CP_RD: begin
        next_r.mem_rd = 1'b1; // R12
        next_r.mem_drive = r.src_drive;
        next_r.mem_file = r.src_file;
        next_r.mem_addr = r.src_addr;
        next_r.st = fach_pkg::FACH_ST_CP_WT;
      end
      fach_pkg::FACH_ST_CP_WT: begin
        if (mem_rvalid) begin
          next_r.mem_wr = 1'b1; // R12
          next_r.mem_drive = r.drive;
          next_r.mem_file = r.file;
          next_r.mem_addr = r.dst_addr;
          next_r.mem_wdata = mem_rdata;
          next_r.src_addr = r.src_addr + 32'h0000_0001;
          next_r.dst_addr = r.dst_addr + 32'h0000_0001;
          next_r.remain = r.remain - 16'h0001;
          if (r.remain == 16'h0001) begin
            next_r.st = fach_pkg::FACH_ST_DONE;
          end else begin
            next_r.st = fach_pkg::FACH_ST_CP_RD;
          end
        end
      end
      fach_pkg::FACH_ST_DONE: begin
        next_r.rsp_valid = 1'b1;
        next_r.rsp_nak = (r.err != `FACH_ERR_NONE); // R16
        next_r.rsp_code = r.err;
        next_r.req_ready = 1'b1;
        next_r.st = fach_pkg::FACH_ST_IDLE;
      end
      default: begin
        next_r.st = fach_pkg::FACH_ST_IDLE;
        next_r.din_ready = 1'b0;
        next_r.req_ready = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.st <= fach_pkg::FACH_ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign req_ready = r.req_ready;
  assign din_ready = r.din_ready;
  assign mem_wr = r.mem_wr;
  assign mem_rd = r.mem_rd;
  assign mem_drive = r.mem_drive;
  assign mem_file = r.mem_file;
  assign mem_addr = r.mem_addr;
  assign mem_wdata = r.mem_wdata;
  assign rsp_valid = r.rsp_valid;
  assign rsp_nak = r.rsp_nak;
  assign rsp_code = r.rsp_code;
  assign acc_denied = r.acc_denied;
endmodule
`default_nettype wire

//--- inc/fach_consts.svh
`ifndef FACH_CONSTS_SVH
`define FACH_CONSTS_SVH
// Byte count limits per request
`define FACH_WR_MAX 16'h03C0
`define FACH_CP_MAX 16'h01E0
// Internal memory drive
`define FACH_DRV_INT 8'h00
// Lock key width and default depth
`define FACH_KEY_W 24
`define FACH_LOCK_N 4
// Answer codes
`define FACH_ERR_NONE 4'h0
`define FACH_ERR_ALIGN 4'h1
`define FACH_ERR_RANGE 4'h2
`define FACH_ERR_COUNT 4'h3
`define FACH_ERR_PROT 4'h4
`define FACH_ERR_LOCK 4'h5
`define FACH_ERR_CMD 4'h6
`endif

//--- inc/fach_if.sv
`timescale 1ns/100ps
`default_nettype none
interface fach_if;
  logic [2:0] cmd;
  logic [7:0] drive;
  logic [7:0] src_drive;
  logic [31:0] offset;
  logic [31:0] size;
  logic [31:0] src_offset;
  logic [31:0] src_size;
  logic [15:0] count;
  logic dst_prot;
  logic src_prot;
  logic cpu_run;
  logic [3:0] err;
  logic lk_set;
  logic lk_clr;
  logic restart;
  logic [23:0] lk_key;
  logic [23:0] acc_key;
  logic lk_hit;
  logic lk_room;
  logic acc_hit;
  modport top (output cmd, drive, src_drive, offset, size, src_offset, src_size, count,
    dst_prot, src_prot, cpu_run, lk_set, lk_clr, restart, lk_key, acc_key,
    input err, lk_hit, lk_room, acc_hit);
  modport chk (input cmd, drive, src_drive, offset, size, src_offset, src_size, count,
    dst_prot, src_prot, cpu_run, output err);
  modport lkp (input lk_set, lk_clr, restart, lk_key, acc_key,
    output lk_hit, lk_room, acc_hit);
endinterface
`default_nettype wire

//--- inc/fach_pkg.sv
package fach_pkg;
  typedef enum logic [2:0] {
    FACH_CMD_WRITE = 3'h0,
    FACH_CMD_FILL = 3'h1,
    FACH_CMD_LOCK_SET = 3'h2,
    FACH_CMD_LOCK_CLR = 3'h3,
    FACH_CMD_COPY = 3'h4
  } fach_cmd_e;
  typedef enum logic [6:0] {
    FACH_ST_IDLE = 7'h01,
    FACH_ST_CHECK = 7'h02,
    FACH_ST_WRITE = 7'h04,
    FACH_ST_FILL = 7'h08,
    FACH_ST_CP_RD = 7'h10,
    FACH_ST_CP_WT = 7'h20,
    FACH_ST_DONE = 7'h40
  } fach_st_e;
  typedef struct packed {
    fach_st_e st;
    logic [2:0] cmd;
    logic [7:0] drive;
    logic [15:0] file;
    logic [7:0] src_drive;
    logic [15:0] src_file;
    logic [31:0] dst_addr;
    logic [31:0] src_addr;
    logic [31:0] size;
    logic [31:0] src_size;
    logic [15:0] remain;
    logic [15:0] pattern;
    logic hi;
    logic dst_prot;
    logic src_prot;
    logic [3:0] err;
    logic req_ready;
    logic din_ready;
    logic mem_wr;
    logic mem_rd;
    logic [7:0] mem_drive;
    logic [15:0] mem_file;
    logic [31:0] mem_addr;
    logic [7:0] mem_wdata;
    logic rsp_valid;
    logic rsp_nak;
    logic [3:0] rsp_code;
    logic lk_set;
    logic lk_clr;
    logic acc_denied;
  } fach_top_s;
endpackage

//--- sim/fach_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module fach_mem_model (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic mem_rd,
  input wire logic [31:0] mem_addr,
  output logic mem_rvalid,
  output logic [7:0] mem_rdata
);
  logic [1:0] dly;
  logic [7:0] held;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dly <= 2'h0;
      held <= 8'h00;
      mem_rvalid <= 1'b0;
      mem_rdata <= 8'hFF;
    end else begin
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_rd && !slow) begin
        mem_rvalid <= 1'b1;
        mem_rdata <= mem_addr[7:0] ^ 8'h3C;
      end else if (mem_rd) begin
        held <= mem_addr[7:0] ^ 8'h3C;
        dly <= 2'h3;
      end else if (dly != 2'h0) begin
        dly <= dly - 2'h1;
        if (dly == 2'h1) begin
          mem_rvalid <= 1'b1;
          mem_rdata <= held;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/fach_top_props.sv
`timescale 1ns/100ps
`default_nettype none
module fach_top_props (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [2:0] req_cmd,
  input wire logic [7:0] req_drive,
  input wire logic [31:0] req_offset,
  input wire logic [31:0] req_size,
  input wire logic req_dst_param,
  input wire logic [15:0] req_count,
  input wire logic cpu_run,
  input wire logic cpu_restart,
  input wire logic mem_wr,
  input wire logic din_ready,
  input wire logic rsp_valid,
  input wire logic rsp_nak,
  input wire logic [3:0] rsp_code,
  input wire logic acc_denied
);
  logic take;
  assign take = req_valid && req_ready;
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_bad_cmd_nak: assert property (take && req_cmd > 3'h4 |-> ##3 rsp_valid && rsp_nak && rsp_code == 4'h6)
    else $error("bad command not refused");
  a_prot_nak: assert property ((take && req_cmd == 3'h0 && req_dst_param ##1 cpu_run) |-> ##2 rsp_valid && rsp_nak && rsp_code == 4'h4)
    else $error("protected file not refused");
  a_write_count_nak: assert property (take && req_cmd == 3'h0 && req_count > 16'h03C0 |-> (!mem_wr && !din_ready)[*3] ##1 rsp_valid && rsp_nak)
    else $error("long write not refused");
  a_copy_count_nak: assert property (take && req_cmd == 3'h4 && req_count > 16'h01E0 |-> ##3 rsp_valid && rsp_nak)
    else $error("long copy not refused");
  a_range_nak: assert property (take && req_cmd < 3'h2 && req_offset >= req_size |-> ##3 rsp_valid && rsp_nak)
    else $error("offset past file not refused");
  a_align_int_nak: assert property (take && req_cmd == 3'h0 && req_drive == 8'h00 && req_offset[1:0] != 2'h0 |-> ##3 rsp_valid && rsp_nak)
    else $error("unaligned internal offset not refused");
  a_align_ext_nak: assert property (take && req_cmd == 3'h1 && req_drive != 8'h00 && req_offset[0] |-> ##3 rsp_valid && rsp_nak)
    else $error("odd offset not refused");
  a_clear_ack: assert property (take && req_cmd == 3'h3 |-> ##3 rsp_valid && !rsp_nak)
    else $error("lock clear not acknowledged");
  a_restart_unlock: assert property (cpu_restart && req_ready |=> ##1 !acc_denied)
    else $error("lock kept over restart");
endmodule
bind fach_top fach_top_props u_props (.sys_clk, .rstn, .req_valid, .req_ready, .req_cmd,
  .req_drive, .req_offset, .req_size, .req_dst_param, .req_count, .cpu_run, .cpu_restart,
  .mem_wr, .din_ready, .rsp_valid, .rsp_nak, .rsp_code, .acc_denied);
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic sys_clk, rstn, req_valid, req_ready, req_dst_param, req_dst_exec, req_src_param;
  logic din_valid, din_ready, mem_wr, mem_rd, mem_rvalid, rsp_valid, rsp_nak, req_src_exec;
  logic cpu_run, cpu_restart, acc_denied, slow, nak;
  logic [2:0] req_cmd;
  logic [7:0] req_drive, req_src_drive, req_attr, din_data, mem_drive, mem_wdata;
  logic [7:0] mem_rdata, acc_drive;
  logic [15:0] req_count, req_pattern, mem_file, acc_file;
  logic [31:0] req_offset, req_size, req_src_offset, req_src_size, mem_addr;
  logic [3:0] rsp_code, code;
  logic [31:0] wa[$];
  logic [7:0] wd[$];
  int fails, checks;
  fach_top #(.LOCK_N(4)) dut (.sys_clk, .rstn, .req_valid, .req_ready, .req_cmd, .req_drive,
    .req_file(16'h0007), .req_offset, .req_size, .req_dst_param, .req_dst_exec,
    .req_src_drive, .req_src_file(16'h0002), .req_src_offset, .req_src_size, .req_src_param,
    .req_src_exec, .req_count, .req_pattern, .req_attr, .din_valid, .din_ready,
    .din_data, .mem_wr, .mem_rd, .mem_drive, .mem_file, .mem_addr, .mem_wdata, .mem_rvalid,
    .mem_rdata, .rsp_valid, .rsp_nak, .rsp_code, .cpu_run, .cpu_restart, .acc_drive,
    .acc_file, .acc_denied);
  fach_mem_model pm (.sys_clk, .rstn, .slow, .mem_rd, .mem_addr, .mem_rvalid, .mem_rdata);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic dst(input logic [7:0] d, input logic [31:0] o, s, input logic [15:0] n);
    req_drive <= d;
    req_offset <= o;
    req_size <= s;
    req_count <= n;
  endtask
  task automatic issue(input logic [2:0] c);
    int n, k, lat;
    wa = {};
    wd = {};
    k = 0;
    n = 0;
    lat = 0;
    req_cmd <= c;
    req_valid <= 1'b1;
    din_valid <= 1'b1;
    din_data <= 8'h5A;
    do begin
      @(posedge sys_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 20);
    req_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && lat < 4000) begin
      @(posedge sys_clk);
      lat++;
      if (din_ready === 1'b1) begin
        k++;
        din_data <= 8'h5A ^ k[7:0];
      end
      if (mem_wr === 1'b1) begin
        wa.push_back(mem_addr);
        wd.push_back(mem_wdata);
        chk({mem_drive, mem_file}, {req_drive, 16'h0007});
      end
      if (mem_rd === 1'b1) begin
        chk({mem_drive, mem_file}, {req_src_drive, 16'h0002});
      end
    end
    din_valid <= 1'b0;
    if (lat >= 4000 || n >= 20) begin
      fails++;
      end_sim();
    end
    nak = rsp_nak;
    code = rsp_code;
  endtask
  task automatic run(input logic [2:0] c, input logic [3:0] e);
    issue(c);
    chk({nak, code}, {e != 4'h0, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_write;
    req_attr <= 8'hFF;
    dst(8'h01, 32'h2, 32'h64, 16'h3);
    run(3'h0, 4'h0);
    chk(wa.size(), 32'h3);
    for (int i = 0; i < 3; i++) begin
      chk(wa[i], 32'h2 + i);
      chk(wd[i], 8'h5A ^ i);
    end
    dst(8'h01, 32'h2, 32'h64, 16'h0);
    run(3'h0, 4'h0);
    chk(wa.size(), 32'h0);
    dst(8'h01, 32'h0, 32'h400, 16'h03C0);
    run(3'h0, 4'h0);
    chk(wa.size(), 32'h3C0);
    dst(8'h01, 32'h0, 32'h400, 16'h03C1);
    run(3'h0, 4'h3);
    dst(8'h01, 32'h3C0, 32'h400, 16'h0028);
    run(3'h0, 4'h0);
    chk(wa.size(), 32'h28);
    chk(wa[0], 32'h3C0);
    dst(8'h00, 32'h2, 32'h64, 16'h1);
    run(3'h0, 4'h1);
    dst(8'h01, 32'h3, 32'h64, 16'h1);
    run(3'h1, 4'h1);
    dst(8'h01, 32'h64, 32'h64, 16'h1);
    run(3'h0, 4'h2);
  endtask
  task automatic t_prot;
    cpu_run <= 1'b1;
    req_dst_param <= 1'b1;
    dst(8'h01, 32'h0, 32'h64, 16'h1);
    run(3'h0, 4'h4);
    req_dst_param <= 1'b0;
    req_dst_exec <= 1'b1;
    dst(8'h00, 32'h0, 32'h64, 16'h1);
    run(3'h1, 4'h4);
    dst(8'h01, 32'h0, 32'h64, 16'h1);
    run(3'h0, 4'h0);
    req_dst_exec <= 1'b0;
    req_src_param <= 1'b1;
    run(3'h4, 4'h4);
    req_src_param <= 1'b0;
    req_src_exec <= 1'b1;
    run(3'h4, 4'h4);
    req_src_exec <= 1'b0;
    cpu_run <= 1'b0;
    req_dst_param <= 1'b1;
    run(3'h0, 4'h0);
    req_dst_param <= 1'b0;
  endtask
  task automatic t_fill;
    req_pattern <= 16'hBEEF;
    dst(8'h00, 32'h4, 32'h64, 16'h3);
    run(3'h1, 4'h0);
    chk(wa.size(), 32'h3);
    for (int i = 0; i < 3; i++) begin
      chk(wa[i], 32'h4 + i);
      chk(wd[i], (i == 1) ? 8'hBE : 8'hEF);
    end
    dst(8'h01, 32'h0, 32'h400, 16'h03C1);
    run(3'h1, 4'h3);
  endtask
  task automatic t_copy;
    req_src_drive <= 8'h00;
    req_src_offset <= 32'h4;
    req_src_size <= 32'h400;
    slow <= 1'b1;
    dst(8'h01, 32'h2, 32'h64, 16'h2);
    run(3'h4, 4'h0);
    chk(wa.size(), 32'h2);
    for (int i = 0; i < 2; i++) begin
      chk(wa[i], 32'h2 + i);
      chk(wd[i], (8'h4 + i) ^ 8'h3C);
    end
    slow <= 1'b0;
    dst(8'h01, 32'h0, 32'h400, 16'h01E0);
    run(3'h4, 4'h0);
    chk(wa.size(), 32'h1E0);
    dst(8'h01, 32'h0, 32'h400, 16'h01E1);
    run(3'h4, 4'h3);
    req_src_offset <= 32'h2;
    dst(8'h01, 32'h2, 32'h64, 16'h2);
    run(3'h4, 4'h1);
    req_src_offset <= 32'h4;
    dst(8'h01, 32'h1, 32'h64, 16'h2);
    run(3'h4, 4'h1);
    req_src_offset <= 32'h400;
    dst(8'h01, 32'h2, 32'h64, 16'h2);
    run(3'h4, 4'h2);
  endtask
  task automatic t_lock;
    acc_drive <= 8'h01;
    acc_file <= 16'h0007;
    dst(8'h01, 32'h0, 32'h0, 16'h0);
    run(3'h2, 4'h0);
    repeat (2) @(posedge sys_clk);
    chk(acc_denied, 1'b1);
    run(3'h3, 4'h0);
    repeat (2) @(posedge sys_clk);
    chk(acc_denied, 1'b0);
    for (int d = 1; d < 6; d++) begin
      dst(d[7:0], 32'h0, 32'h0, 16'h0);
      run(3'h2, (d == 5) ? 4'h5 : 4'h0);
    end
    chk(acc_denied, 1'b1);
    cpu_restart <= 1'b1;
    @(posedge sys_clk);
    cpu_restart <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(acc_denied, 1'b0);
    for (int c = 5; c < 8; c++) begin
      run(c[2:0], 4'h6);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, req_valid, req_dst_param, req_dst_exec, req_src_param, req_src_exec, din_valid} = '0;
    {cpu_run, cpu_restart, slow, req_cmd, req_drive, req_src_drive, req_attr} = '0;
    {din_data, acc_drive, req_count, req_pattern, acc_file} = '0;
    {req_offset, req_size, req_src_offset, req_src_size} = '0;
    fails = 0;
    checks = 0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    t_write();
    t_prot();
    t_fill();
    t_copy();
    t_lock();
    end_sim();
  end
endmodule
`default_nettype wire
